// [hw/servo_alarm_detect.sv]
// alarm detector with axi4-lite register slave and level interrupt
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module servo_alarm_detect #(
    parameter int VAL_W = 48
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // same-clock inputs from the command path
    input wire logic signed [31:0] cmd_step,
    input wire logic cmd_step_valid,
    input wire logic cmd_arith_fault,
    input wire logic signed [VAL_W-1:0] init_scaled_pos,
    input wire logic init_valid,
    input wire logic signed [VAL_W-1:0] pos_err_pulses,
    input wire logic signed [VAL_W-1:0] pos_err_cmd_units,
    input wire logic pos_err_valid,
    input wire logic tool_op_start,
    input wire logic tool_op_active,
    // asynchronous pins
    input wire logic fieldbus_link_up,
    input wire logic safety_input_1,
    input wire logic safety_input_2,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic encoder_supply_lost,
    input wire logic battery_supply_lost,
    input wire logic backup_cap_low,
    // alarm report
    output logic alarm_active,
    output logic [7:0] alarm_main,
    output logic [7:0] alarm_sub,
    output logic irq
);
    import servo_alarm_pkg::*;

    // ******************************
    // state
    // ******************************
    typedef struct packed {
        alarm_state_e st;           // alarm holder
        logic [7:0] alm_main;       // held main number
        logic [7:0] alm_sub;        // held sub number
        logic setup_done;           // encoder set up since last backup loss
        logic [NUM_PINS-1:0] sync1; // first synchroniser stage
        logic [NUM_PINS-1:0] sync2; // second stage, safe to use
        logic [NUM_PINS-1:0] prev;  // previous value for edges
        logic [1:0] prohib_sel;     // prohibition_input_select
        logic [31:0] cmd_limit;
        logic [31:0] origin_dist;   // origin_return_final_distance
        logic [31:0] gear_num;
        logic [31:0] gear_den;
        logic [NUM_EV-1:0] irq_status;
        logic [NUM_EV-1:0] irq_enable;
        logic irq;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    state_s state_reg;  // registered state
    state_s state_next; // next state

    // ******************************
    // helpers
    // ******************************
    // true when |v| is strictly above lim
    function automatic logic over_mag(input logic signed [63:0] v,
                                      input logic signed [63:0] lim);
        return (v > lim) || (v < -lim);
    endfunction

    // byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [NUM_PINS-1:0] pin_raw; // pins gathered for the synchroniser
    assign pin_raw = {backup_cap_low, battery_supply_lost, encoder_supply_lost,
                      reverse_limit_input, forward_limit_input, safety_input_2,
                      safety_input_1, fieldbus_link_up};

    // ******************************
    // next-state logic
    // ******************************
    always_comb begin
        logic [NUM_EV-1:0] ev;        // events detected this cycle
        logic [NUM_EV-1:0] clr;       // software clear mask
        logic signed [63:0] origin_prod;
        logic fwd;
        logic rev;
        logic lim_rise;
        logic do_write;
        logic clear_req;
        logic setup_req;
        logic [31:0] wword;
        ev = '0;
        clr = '0;
        // distance is signed, so extend its sign before the product
        origin_prod = 64'(signed'(state_reg.origin_dist)) * 64'({32'h0, state_reg.gear_num});
        fwd = state_reg.sync2[PIN_FWD];
        rev = state_reg.sync2[PIN_REV];
        lim_rise = (fwd & ~state_reg.prev[PIN_FWD]) | (rev & ~state_reg.prev[PIN_REV]);
        do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        clear_req = 1'b0;
        setup_req = 1'b0;
        wword = '0;
        state_next = state_reg;

        // pins: two flops, then an edge-detect copy of stage two
        state_next.sync1 = pin_raw;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;

        // event detection
        ev[EV_CMD_STEP] = cmd_step_valid
            && over_mag(64'(cmd_step), 64'({32'h0, state_reg.cmd_limit})); // [R1]
        ev[EV_CMD_ARITH] = cmd_arith_fault; // [R2]
        // link coming up under a tool-driven run
        ev[EV_OP_DUP] = state_reg.sync2[PIN_LINK] && !state_reg.prev[PIN_LINK]
            && tool_op_active; // [R3]
        ev[EV_INIT_OVF] = init_valid && over_mag(64'(init_scaled_pos), LIM_2P31); // [R4]
        ev[EV_ERR_OVF] = pos_err_valid
            && (over_mag(64'(pos_err_pulses), LIM_2P29) // [R5]
            || over_mag(64'(pos_err_cmd_units), LIM_2P30)); // [R6]
        // limit is 2^31 times the denominator; zero denominator is ignored
        ev[EV_ORIGIN_OVF] = (state_reg.gear_den != 32'h0)
            && over_mag(origin_prod, {1'b0, state_reg.gear_den, 31'h0}); // [R7]
        ev[EV_SAFETY] = !state_reg.sync2[PIN_SAFE1] || !state_reg.sync2[PIN_SAFE2]; // [R8]
        ev[EV_PROHIB1] = ((state_reg.prohib_sel == SEL_BOTH) && fwd && rev) // [R9]
            || ((state_reg.prohib_sel == SEL_EITHER) && (fwd || rev)); // [R10]
        ev[EV_PROHIB2] = ((state_reg.prohib_sel == SEL_BOTH) && tool_op_start
            && !state_reg.sync2[PIN_LINK] && (fwd || rev)) // [R11]
            || (tool_op_active && lim_rise); // [R12]
        // capacitor only counts once both supplies are gone
        ev[EV_BACKUP] = state_reg.sync2[PIN_CAP_LOW] && state_reg.sync2[PIN_ENC_LOST]
            && state_reg.sync2[PIN_BAT_LOST]; // [R13]

        // axi write channels: each is taken on its own, write when both held
        if (s_axi_awvalid && !state_reg.aw_held) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_held) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = RESP_OKAY;
            wword = merge(32'h0, state_reg.w_data, state_reg.w_strb);
            case ({state_reg.aw_addr[7:2], 2'b00})
                OFS_CTRL: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.prohib_sel = wword[CTRL_SEL_LSB +: 2];
                    end
                    // command bits act as one-cycle strobes
                    clear_req = state_reg.w_strb[1] && wword[CTRL_CLEAR_BIT];
                    setup_req = state_reg.w_strb[1] && wword[CTRL_SETUP_BIT];
                end
                OFS_CMD_LIMIT: begin
                    state_next.cmd_limit = merge(state_reg.cmd_limit, state_reg.w_data,
                                                 state_reg.w_strb);
                end
                OFS_ORIGIN_DIST: begin
                    state_next.origin_dist = merge(state_reg.origin_dist, state_reg.w_data,
                                                   state_reg.w_strb);
                end
                OFS_GEAR_NUM: begin
                    state_next.gear_num = merge(state_reg.gear_num, state_reg.w_data,
                                                state_reg.w_strb);
                end
                OFS_GEAR_DEN: begin
                    state_next.gear_den = merge(state_reg.gear_den, state_reg.w_data,
                                                state_reg.w_strb);
                end
                OFS_IRQ_CLEAR: begin
                    clr = wword[NUM_EV-1:0];
                end
                OFS_IRQ_ENABLE: begin
                    state_next.irq_enable = wword[NUM_EV-1:0];
                end
                OFS_ALARM, OFS_IRQ_STATUS, OFS_PIN_STATE: begin
                    // read-only, write ignored
                end
                default: begin
                    state_next.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // axi read: one word, answered the cycle after the address
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            state_next.rdata = '0;
            case ({s_axi_araddr[7:2], 2'b00})
                OFS_CTRL: state_next.rdata[CTRL_SEL_LSB +: 2] = state_reg.prohib_sel;
                OFS_CMD_LIMIT: state_next.rdata = state_reg.cmd_limit;
                OFS_ORIGIN_DIST: state_next.rdata = state_reg.origin_dist;
                OFS_GEAR_NUM: state_next.rdata = state_reg.gear_num;
                OFS_GEAR_DEN: state_next.rdata = state_reg.gear_den;
                OFS_ALARM: begin
                    state_next.rdata = {15'h0, state_reg.st == ALM_HELD,
                                        state_reg.alm_main, state_reg.alm_sub};
                end
                OFS_IRQ_STATUS: state_next.rdata[NUM_EV-1:0] = state_reg.irq_status;
                OFS_IRQ_CLEAR: state_next.rdata = '0;
                OFS_IRQ_ENABLE: state_next.rdata[NUM_EV-1:0] = state_reg.irq_enable;
                OFS_PIN_STATE: begin
                    state_next.rdata[NUM_PINS-1:0] = state_reg.sync2;
                    state_next.rdata[PIN_SETUP_BIT] = state_reg.setup_done;
                end
                default: state_next.rresp = RESP_SLVERR;
            endcase
        end

        // sticky status: a new event beats a clear in the same cycle
        state_next.irq_status = (state_reg.irq_status & ~clr) | ev;
        state_next.irq = |(state_next.irq_status & state_reg.irq_enable);

        // setup only counts with the battery back; a new loss voids it
        if (ev[EV_BACKUP]) begin
            state_next.setup_done = 1'b0; // [R14]
        end else if (setup_req && !state_reg.sync2[PIN_BAT_LOST]) begin
            state_next.setup_done = 1'b1; // [R14]
        end

        // alarm holder: first event wins, kept until an accepted clear
        case (state_reg.st)
            ALM_IDLE: begin
                for (int i = NUM_EV - 1; i >= 0; i--) begin
                    if (ev[i]) begin
                        state_next.alm_main = EV_MAIN[i]; // [R15]
                        state_next.alm_sub = EV_SUB[i]; // [R15]
                    end
                end
                if (|ev) begin
                    state_next.st = ALM_HELD;
                end
            end
            ALM_HELD: begin
                // backup alarm stays until the encoder is set up again
                if (clear_req && (state_reg.alm_main != MAIN_BACKUP
                    || state_reg.setup_done)) begin // [R14]
                    state_next.st = ALM_IDLE;
                    state_next.alm_main = '0;
                    state_next.alm_sub = '0;
                end
            end
            default: begin
                state_next.st = ALM_IDLE;
            end
        endcase
    end

    // ******************************
    // state register, synchronous reset
    // ******************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.st <= ALM_IDLE;
            state_reg.prohib_sel <= RST_SEL;
            state_reg.cmd_limit <= RST_CMD_LIMIT;
            state_reg.origin_dist <= RST_ORIGIN_DIST;
            state_reg.gear_num <= RST_GEAR;
            state_reg.gear_den <= RST_GEAR;
            state_reg.irq_status <= RST_IRQ;
            state_reg.irq_enable <= RST_IRQ;
            // safety inputs read as on until sampled, avoiding a reset alarm
            state_reg.sync1 <= 8'h06;
            state_reg.sync2 <= 8'h06;
            state_reg.prev <= 8'h06;
        end else begin
            state_reg <= state_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign s_axi_awready = !state_reg.aw_held;
    assign s_axi_wready = !state_reg.w_held;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign alarm_active = (state_reg.st == ALM_HELD);
    assign alarm_main = state_reg.alm_main;
    assign alarm_sub = state_reg.alm_sub;
    assign irq = state_reg.irq;

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ev_origin_seen; // helper for the origin overflow check
    assign ev_origin_seen = (state_reg.gear_den != 32'h0)
        && over_mag(64'(signed'(state_reg.origin_dist)) * 64'({32'h0, state_reg.gear_num}),
                    {1'b0, state_reg.gear_den, 31'h0});

    a_cmd_step: assert property (cmd_step_valid
        && 64'(cmd_step) > $signed({32'h0, state_reg.cmd_limit})
        |=> state_reg.irq_status[EV_CMD_STEP]) else $error("command step alarm missed"); // [R1]
    a_arith_fault: assert property (cmd_arith_fault |=> state_reg.irq_status[EV_CMD_ARITH])
        else $error("arith fault alarm missed"); // [R2]
    a_op_dup: assert property ($rose(state_reg.sync2[PIN_LINK]) && tool_op_active
        |=> state_reg.irq_status[EV_OP_DUP]) else $error("duplicate op alarm missed"); // [R3]
    a_init_ovf: assert property (init_valid && 64'(init_scaled_pos) < -LIM_2P31
        |=> state_reg.irq_status[EV_INIT_OVF]) else $error("init overflow missed"); // [R4]
    a_err_pulse: assert property (pos_err_valid && 64'(pos_err_pulses) > LIM_2P29
        |=> state_reg.irq_status[EV_ERR_OVF]) else $error("pulse error overflow missed"); // [R5]
    a_err_cmd: assert property (pos_err_valid && 64'(pos_err_cmd_units) == LIM_2P30
        && 64'(pos_err_pulses) == 64'sh0 && !state_reg.irq_status[EV_ERR_OVF]
        |=> !state_reg.irq_status[EV_ERR_OVF]) else $error("error limit is exclusive"); // [R6]
    a_origin_ovf: assert property (ev_origin_seen |=> state_reg.irq_status[EV_ORIGIN_OVF])
        else $error("origin overflow missed"); // [R7]
    a_safety_off: assert property (!state_reg.sync2[PIN_SAFE1] || !state_reg.sync2[PIN_SAFE2]
        |=> state_reg.irq_status[EV_SAFETY]) else $error("safety alarm missed"); // [R8]
    a_limit_sel: assert property (state_reg.prohib_sel == SEL_EITHER && state_reg.sync2[PIN_REV]
        |=> state_reg.irq_status[EV_PROHIB1]) else $error("limit alarm missed"); // [R10]
    a_limit_both: assert property (state_reg.prohib_sel == SEL_BOTH && state_reg.sync2[PIN_REV]
        && state_reg.sync2[PIN_FWD] |=> state_reg.irq_status[EV_PROHIB1])
        else $error("both-limit alarm missed"); // [R9]
    a_tool_cmd: assert property (state_reg.prohib_sel == SEL_BOTH && tool_op_start
        && !state_reg.sync2[PIN_LINK] && state_reg.sync2[PIN_FWD]
        |=> state_reg.irq_status[EV_PROHIB2]) else $error("tool command alarm missed"); // [R11]
    a_tool_limit: assert property (tool_op_active && $rose(state_reg.sync2[PIN_REV])
        |=> state_reg.irq_status[EV_PROHIB2]) else $error("tool limit alarm missed"); // [R12]
    a_backup_loss: assert property (&state_reg.sync2[PIN_CAP_LOW:PIN_ENC_LOST]
        |=> state_reg.irq_status[EV_BACKUP] && !state_reg.setup_done)
        else $error("backup alarm missed"); // [R13]
    a_clear_refused: assert property (alarm_active && alarm_main == MAIN_BACKUP
        && !state_reg.setup_done |=> alarm_active) else $error("backup alarm cleared early"); // [R14]
    a_pair_hold: assert property (alarm_active ##1 alarm_active
        |-> $stable(alarm_main) && $stable(alarm_sub)) else $error("alarm pair changed"); // [R15]

    c_safety_alarm: cover property (alarm_active && alarm_main == 8'h1E);
    c_backup_cleared: cover property (alarm_main == MAIN_BACKUP ##[1:200] !alarm_active);
    c_irq_raise: cover property ($rose(irq));
endmodule

// [hw/servo_alarm_pkg.sv]
// constants, codes and register map for the servo alarm detector
// Behaviour
// [R1] alarm 27.4 on oversized scaled command step
// [R2] alarm 27.5 on command arithmetic fault
// [R3] alarm 27.6: link up during tool run
// [R4] alarm 29.1 on init position overflow
// [R5] alarm 29.2 on pulse position error overflow
// [R6] alarm 29.2 on command-unit error overflow
// [R7] alarm 29.3 on origin distance times gear overflow
// [R8] alarm 30.0 when either safety input off
// [R9] select 0: both limits on gives 38.0
// [R10] select 2: either limit on gives 38.0
// [R11] select 0, link down, limit: tool command 38.1
// [R12] limit turning on during tool run: 38.1
// [R13] alarm 40.0 on backup capacitor loss
// [R14] alarm 40 clear needs encoder setup after battery
// [R15] hold main/sub pair until cleared
package servo_alarm_pkg;
    // ******************************
    // register byte offsets
    // ******************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD_LIMIT = 8'h04;
    localparam logic [7:0] OFS_ORIGIN_DIST = 8'h08;
    localparam logic [7:0] OFS_GEAR_NUM = 8'h0C;
    localparam logic [7:0] OFS_GEAR_DEN = 8'h10;
    localparam logic [7:0] OFS_ALARM = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] OFS_PIN_STATE = 8'h24;
    // ******************************
    // control fields and reset values
    // ******************************
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_CLEAR_BIT = 8;
    localparam int CTRL_SETUP_BIT = 9;
    localparam int ALARM_ACTIVE_BIT = 16;
    localparam int PIN_SETUP_BIT = 8;
    localparam logic [1:0] SEL_BOTH = 2'h0;
    localparam logic [1:0] SEL_EITHER = 2'h2;
    localparam logic [1:0] RST_SEL = 2'h0;
    localparam logic [31:0] RST_CMD_LIMIT = 32'hFFFFFFFF;
    localparam logic [31:0] RST_ORIGIN_DIST = 32'h00000000;
    localparam logic [31:0] RST_GEAR = 32'h00000001;
    localparam logic [9:0] RST_IRQ = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ******************************
    // overflow thresholds (magnitudes)
    // ******************************
    localparam logic signed [63:0] LIM_2P31 = 64'sh0000000080000000;
    localparam logic signed [63:0] LIM_2P29 = 64'sh0000000020000000;
    localparam logic signed [63:0] LIM_2P30 = 64'sh0000000040000000;
    // ******************************
    // synchronised pin positions
    // ******************************
    localparam int PIN_LINK = 0;
    localparam int PIN_SAFE1 = 1;
    localparam int PIN_SAFE2 = 2;
    localparam int PIN_FWD = 3;
    localparam int PIN_REV = 4;
    localparam int PIN_ENC_LOST = 5;
    localparam int PIN_BAT_LOST = 6;
    localparam int PIN_CAP_LOW = 7;
    localparam int NUM_PINS = 8;
    // ******************************
    // events, one status bit each, lowest index wins capture
    // ******************************
    localparam int EV_CMD_STEP = 0;
    localparam int EV_CMD_ARITH = 1;
    localparam int EV_OP_DUP = 2;
    localparam int EV_INIT_OVF = 3;
    localparam int EV_ERR_OVF = 4;
    localparam int EV_ORIGIN_OVF = 5;
    localparam int EV_SAFETY = 6;
    localparam int EV_PROHIB1 = 7;
    localparam int EV_PROHIB2 = 8;
    localparam int EV_BACKUP = 9;
    localparam int NUM_EV = 10;
    localparam logic [9:0][7:0] EV_MAIN = {8'h28, 8'h26, 8'h26, 8'h1E, 8'h1D,
                                           8'h1D, 8'h1D, 8'h1B, 8'h1B, 8'h1B};
    localparam logic [9:0][7:0] EV_SUB = {8'h00, 8'h01, 8'h00, 8'h00, 8'h03,
                                          8'h02, 8'h01, 8'h06, 8'h05, 8'h04};
    localparam logic [7:0] MAIN_BACKUP = 8'h28;
    // alarm holder states
    typedef enum logic [1:0] {
        ALM_IDLE = 2'b01,
        ALM_HELD = 2'b10
    } alarm_state_e;
endpackage

// [testbench/machine_side_model.sv]
// machine side model: limit, safety, link and encoder supply wiring
`timescale 1ns/100ps
module machine_side_model (
    input wire logic [7:0] pin_req,
    output logic [7:0] pins
);
    // wiring delay keeps pin edges away from the clock edge
    assign #2 pins = pin_req;
endmodule

// [testbench/servo_alarm_detect_tb.sv]
// self-checking bench for the servo alarm detector
`timescale 1ns/100ps
module servo_alarm_detect_tb;
    import servo_alarm_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] aa = 0, pq = 8'h06; // safeties start on
    logic [31:0] wd = 0, q;
    logic [1:0] rs;
    logic signed [31:0] stp = 0;
    logic signed [47:0] ep = 0, ec = 0, ip = 0;
    logic sv = 0, af = 0, ev = 0, iv = 0, ts = 0, ta = 0;
    wire logic [7:0] pn, am, as;
    wire logic awr, wrd, bv, arr, rv, ac, irq;
    wire logic [1:0] br, rr;
    wire logic [31:0] rd;
    int err_count = 0, num_checks = 0;
    servo_alarm_detect i_servo_alarm_detect (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(aa), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .cmd_step(stp), .cmd_step_valid(sv), .cmd_arith_fault(af), .init_scaled_pos(ip),
        .init_valid(iv), .pos_err_pulses(ep), .pos_err_cmd_units(ec), .pos_err_valid(ev),
        .tool_op_start(ts), .tool_op_active(ta), .fieldbus_link_up(pn[0]),
        .safety_input_1(pn[1]), .safety_input_2(pn[2]), .forward_limit_input(pn[3]),
        .reverse_limit_input(pn[4]), .encoder_supply_lost(pn[5]),
        .battery_supply_lost(pn[6]), .backup_cap_low(pn[7]), .alarm_active(ac),
        .alarm_main(am), .alarm_sub(as), .irq(irq));
    machine_side_model i_machine_side_model (.pin_req(pq), .pins(pn));
    initial forever #12.5 aclk = ~aclk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one axi4-lite write or read; handshakes judged at the falling edge
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic [4:0] k;
        @(posedge aclk) aa <= a;
        {wd, awv, wv, bry, arv, rry} <= {d, w, w, w, !w, !w};
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (!(awv || wv || bry || arv || rry)) break;
            k = {awv & awr, wv & wrd, bry & bv, arv & arr, rry & rv};
            if (k[2] || k[0]) q = rd;
            if (k[2] || k[0]) rs = k[2] ? br : rr;
            @(posedge aclk) {awv, wv, bry, arv, rry} <= {awv, wv, bry, arv, rry} & ~k;
        end
        if (n == 40) begin
            err_count++;
            end_of_test;
        end
    endtask
    task automatic hit(input logic [16:0] e); // settle, then compare held pair
        repeat (6) @(posedge aclk);
        chk({15'h0000, ac, am, as}, {15'h0000, e});
    endtask
    task automatic clr(input logic [1:0] s); // clear strobe plus selection
        bus(1, OFS_CTRL, {22'h000000, 2'h1, 6'h00, s});
        hit(17'h00000);
    endtask
    task automatic t_regs;
        bus(0, OFS_CMD_LIMIT, 32'h0);
        chk(q, RST_CMD_LIMIT);
        bus(0, 8'h40, 32'h0); // unmapped place
        chk({q[31:2], rs}, {30'h0, RESP_SLVERR});
        bus(1, 8'h40, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        bus(1, OFS_CMD_LIMIT, 32'h00000064);
        @(posedge aclk) stp <= 32'sh00000064;
        sv <= 1;
        hit(17'h00000);
        @(posedge aclk) stp <= 32'sh00000065;
        hit(17'h11B04);
        sv <= 0;
        clr(2'h0);
    endtask
    task automatic t_arith;
        bus(1, OFS_IRQ_ENABLE, 32'h00000002);
        @(posedge aclk) af <= 1;
        @(posedge aclk) af <= 0;
        hit(17'h11B05);
        chk({31'h0, irq}, 32'h1);
        hit(17'h11B05);
        bus(1, OFS_IRQ_CLEAR, 32'h00000002);
        hit(17'h11B05);
        chk({31'h0, irq}, 32'h0);
        clr(2'h0);
    endtask
    // error counter boundaries: exactly at the limit is no alarm
    task automatic t_err;
        @(posedge aclk) ep <= 48'sh000020000000;
        ev <= 1;
        hit(17'h00000);
        @(posedge aclk) ep <= 48'sh000020000001;
        hit(17'h11D02);
        ep <= 0;
        clr(2'h0);
        @(posedge aclk) ec <= 48'sh000040000001;
        hit(17'h11D02);
        ec <= 0;
        clr(2'h0);
    endtask
    task automatic t_pins;
        @(posedge aclk) pq[PIN_SAFE2] <= 0;
        hit(17'h11E00);
        pq[PIN_SAFE2] <= 1;
        clr(2'h2);
        @(posedge aclk) pq[PIN_REV] <= 1;
        hit(17'h12600);
        pq[PIN_REV] <= 0;
        clr(2'h0);
        @(posedge aclk) pq[PIN_FWD] <= 1;
        hit(17'h00000);
        pq[PIN_REV] <= 1;
        hit(17'h12600);
        pq[4:3] <= 2'h0;
        clr(2'h0);
    endtask
    // init and origin overflow, link up and limits under a tool run
    task automatic t_tool;
        @(posedge aclk) ip <= -48'sh000080000001;
        iv <= 1;
        hit(17'h11D01);
        iv <= 0;
        clr(2'h0);
        bus(1, OFS_GEAR_NUM, 32'h00000002);
        bus(1, OFS_ORIGIN_DIST, 32'h40000001);
        hit(17'h11D03);
        bus(1, OFS_GEAR_NUM, 32'h00000001);
        clr(2'h0);
        @(posedge aclk) ta <= 1;
        pq[PIN_LINK] <= 1;
        hit(17'h11B06);
        clr(2'h0);
        pq[PIN_FWD] <= 1;
        hit(17'h12601);
        ta <= 0;
        pq[PIN_LINK] <= 0;
        clr(2'h0);
        @(posedge aclk) ts <= 1;
        @(posedge aclk) ts <= 0;
        hit(17'h12601);
        pq[PIN_FWD] <= 0;
        clr(2'h0);
    endtask
    // backup loss: clear is refused until setup after battery returns
    task automatic t_backup;
        @(posedge aclk) pq[7:5] <= 3'h7;
        hit(17'h12800);
        pq[7:5] <= 3'h2;
        bus(1, OFS_CTRL, 32'h00000100);
        hit(17'h12800);
        pq[PIN_BAT_LOST] <= 0;
        bus(1, OFS_CTRL, 32'h00000200);
        clr(2'h0);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_arith;
        t_err;
        t_pins;
        t_tool;
        t_backup;
        end_of_test;
    end
endmodule
